// >>> rtl/lciw_cfg.svh
// Register map, field positions, reset values and key of the display interrupt and lock block.
`ifndef LCIW_CFG_SVH
`define LCIW_CFG_SVH

`define LCIW_OFS_IRQ_ENABLE 32'h0050_0848
`define LCIW_OFS_IRQ_DISABLE 32'h0050_084C
`define LCIW_OFS_IRQ_MASK 32'h0050_0850
`define LCIW_OFS_IRQ_STATUS 32'h0050_0854
`define LCIW_OFS_IRQ_CLEAR 32'h0050_0858
`define LCIW_OFS_IRQ_FORCE 32'h0050_0860
`define LCIW_OFS_IRQ_RAW 32'h0050_0864
`define LCIW_OFS_LOCK_MODE 32'h0050_08E4
`define LCIW_OFS_LOCK_STATUS 32'h0050_08E8
`define LCIW_OFS_PROT_FIRST 32'h0050_0800
`define LCIW_OFS_PROT_LAST 32'h0050_0838

`define LCIW_IRQ_LINE 0
`define LCIW_IRQ_LAST_LINE 1
`define LCIW_IRQ_FRAME_END 2
`define LCIW_IRQ_FIFO_UNDER 4
`define LCIW_IRQ_FIFO_OVER 5
`define LCIW_IRQ_DMA_FAULT 6
`define LCIW_IRQ_VALID 7'h77
`define LCIW_IRQ_RESET 7'h00

`define LCIW_LOCK_EN_BIT 0
`define LCIW_LOCK_KEY_LSB 8
`define LCIW_LOCK_KEY_MSB 31
`define LCIW_LOCK_KEY 24'h4C_4344
`define LCIW_LOCK_EN_RESET 1'b0
`define LCIW_VIOL_FLAG_BIT 0
`define LCIW_VIOL_SRC_LSB 8
`define LCIW_VIOL_SRC_MSB 23

`endif

// >>> rtl/lciw_pkg.sv
// Types shared by the display interrupt and lock block.
package lciw_pkg;
	typedef logic [31:0] lciw_word_t;
	typedef logic [6:0] lciw_irq_t;
	typedef logic [15:0] lciw_src_t;
	typedef enum {
		LCIW_SEL_NONE,
		LCIW_SEL_IRQ_ENABLE,
		LCIW_SEL_IRQ_DISABLE,
		LCIW_SEL_IRQ_MASK,
		LCIW_SEL_IRQ_STATUS,
		LCIW_SEL_IRQ_CLEAR,
		LCIW_SEL_IRQ_FORCE,
		LCIW_SEL_IRQ_RAW,
		LCIW_SEL_LOCK_MODE,
		LCIW_SEL_LOCK_STATUS,
		LCIW_SEL_PROTECTED
	} lciw_sel_t;
endpackage : lciw_pkg

// >>> rtl/lciw_irq_bank.sv
// Interrupt mask, latched conditions and interrupt line for six display sources.
`timescale 1ns/1ps
`default_nettype none
`include "lciw_cfg.svh"

module lciw_irq_bank (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire lciw_pkg::lciw_irq_t raw_i,
	input wire lciw_pkg::lciw_irq_t enable_i,
	input wire lciw_pkg::lciw_irq_t disable_i,
	input wire lciw_pkg::lciw_irq_t clear_i,
	input wire lciw_pkg::lciw_irq_t force_i,
	output lciw_pkg::lciw_irq_t mask_o,
	output lciw_pkg::lciw_irq_t pend_o,
	output logic irq_o
);
	import lciw_pkg::*;

	lciw_irq_t mask_reg;
	lciw_irq_t mask_next;
	lciw_irq_t pend_reg;
	lciw_irq_t pend_next;
	logic irq_reg;
	logic irq_next;

	always_comb begin
		// Enable wins when software hits the same bit in both commands in one cycle.
		mask_next = (mask_reg & ~disable_i) | enable_i;
		mask_next = mask_next & `LCIW_IRQ_VALID;
		// A condition or a forced set arriving with a clear is kept, so no event is lost.
		pend_next = (pend_reg & ~clear_i) | raw_i | force_i;
		pend_next = pend_next & `LCIW_IRQ_VALID;
		irq_next = |(pend_next & mask_next);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mask_reg <= `LCIW_IRQ_RESET;
			pend_reg <= `LCIW_IRQ_RESET;
			irq_reg <= 1'b0;
		end else begin
			mask_reg <= mask_next;
			pend_reg <= pend_next;
			irq_reg <= irq_next;
		end
	end

	assign mask_o = mask_reg;
	assign pend_o = pend_reg;
	assign irq_o = irq_reg;
endmodule : lciw_irq_bank

`default_nettype wire

// >>> rtl/lciw_top.sv
// Interrupt bookkeeping and keyed write lock of the display controller.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lciw_cfg.svh"

module lciw_top (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire lciw_pkg::lciw_word_t addr_i,
	input wire lciw_pkg::lciw_word_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output lciw_pkg::lciw_word_t rdata_o,
	input wire lciw_pkg::lciw_irq_t irq_raw_i,
	output logic irq_o,
	output logic lock_enable_o,
	output logic cfg_wr_o,
	output lciw_pkg::lciw_word_t cfg_addr_o,
	output lciw_pkg::lciw_word_t cfg_wdata_o
);
	import lciw_pkg::*;

	function automatic lciw_sel_t lciw_decode(input lciw_word_t a);
		lciw_sel_t s;
		s = LCIW_SEL_NONE;
		case (a)
			`LCIW_OFS_IRQ_ENABLE: s = LCIW_SEL_IRQ_ENABLE;
			`LCIW_OFS_IRQ_DISABLE: s = LCIW_SEL_IRQ_DISABLE;
			`LCIW_OFS_IRQ_MASK: s = LCIW_SEL_IRQ_MASK;
			`LCIW_OFS_IRQ_STATUS: s = LCIW_SEL_IRQ_STATUS;
			`LCIW_OFS_IRQ_CLEAR: s = LCIW_SEL_IRQ_CLEAR;
			`LCIW_OFS_IRQ_FORCE: s = LCIW_SEL_IRQ_FORCE;
			`LCIW_OFS_IRQ_RAW: s = LCIW_SEL_IRQ_RAW;
			`LCIW_OFS_LOCK_MODE: s = LCIW_SEL_LOCK_MODE;
			`LCIW_OFS_LOCK_STATUS: s = LCIW_SEL_LOCK_STATUS;
			default: begin
				if (a >= `LCIW_OFS_PROT_FIRST && a <= `LCIW_OFS_PROT_LAST && a[1:0] == 2'h0) begin
					s = LCIW_SEL_PROTECTED;
				end
			end
		endcase
		return s;
	endfunction : lciw_decode

	function automatic lciw_irq_t lciw_cmd(input logic hit, input lciw_word_t d);
		return hit ? (d[6:0] & `LCIW_IRQ_VALID) : `LCIW_IRQ_RESET;
	endfunction : lciw_cmd

	lciw_sel_t sel;
	lciw_irq_t mask_view;
	lciw_irq_t pend_view;
	lciw_irq_t enable_cmd;
	lciw_irq_t disable_cmd;
	lciw_irq_t clear_cmd;
	lciw_irq_t force_cmd;
	logic key_ok;
	logic lock_write;
	logic prot_write;
	logic blocked_write;
	logic viol_read;

	logic lock_en_reg;
	logic lock_en_next;
	logic viol_flag_reg;
	logic viol_flag_next;
	lciw_src_t viol_src_reg;
	lciw_src_t viol_src_next;
	logic cfg_wr_reg;
	logic cfg_wr_next;
	lciw_word_t cfg_addr_reg;
	lciw_word_t cfg_addr_next;
	lciw_word_t cfg_wdata_reg;
	lciw_word_t cfg_wdata_next;
	lciw_word_t rdata_reg;
	lciw_word_t rdata_next;

	always_comb begin
		sel = lciw_decode(addr_i);
		enable_cmd = lciw_cmd(wr_i && sel == LCIW_SEL_IRQ_ENABLE, wdata_i);
		disable_cmd = lciw_cmd(wr_i && sel == LCIW_SEL_IRQ_DISABLE, wdata_i);
		clear_cmd = lciw_cmd(wr_i && sel == LCIW_SEL_IRQ_CLEAR, wdata_i);
		force_cmd = lciw_cmd(wr_i && sel == LCIW_SEL_IRQ_FORCE, wdata_i);
	end

	lciw_irq_bank u_irq_bank (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.raw_i(irq_raw_i),
		.enable_i(enable_cmd),
		.disable_i(disable_cmd),
		.clear_i(clear_cmd),
		.force_i(force_cmd),
		.mask_o(mask_view),
		.pend_o(pend_view),
		.irq_o(irq_o)
	);

	// Lock, violation record and forwarding of configuration writes.
	always_comb begin
		key_ok = wdata_i[`LCIW_LOCK_KEY_MSB:`LCIW_LOCK_KEY_LSB] == `LCIW_LOCK_KEY;
		lock_write = wr_i && sel == LCIW_SEL_LOCK_MODE;
		prot_write = wr_i && sel == LCIW_SEL_PROTECTED;
		blocked_write = prot_write && lock_en_reg;
		viol_read = rd_i && sel == LCIW_SEL_LOCK_STATUS;
		lock_en_next = lock_en_reg;
		if (lock_write && key_ok) begin
			lock_en_next = wdata_i[`LCIW_LOCK_EN_BIT];
		end
		viol_flag_next = viol_flag_reg;
		viol_src_next = viol_src_reg;
		if (viol_read) begin
			viol_flag_next = 1'b0;
			viol_src_next = 16'h0000;
		end
		// A blocked write in the same cycle as the read is kept for the next read.
		if (blocked_write) begin
			viol_flag_next = 1'b1;
			viol_src_next = addr_i[15:0];
		end
		cfg_wr_next = prot_write && !lock_en_reg;
		cfg_addr_next = cfg_addr_reg;
		cfg_wdata_next = cfg_wdata_reg;
		if (cfg_wr_next) begin
			cfg_addr_next = addr_i;
			cfg_wdata_next = wdata_i;
		end
	end

	// Read data stand for exactly one cycle; unmapped and write-only addresses read zero.
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (rd_i) begin
			case (sel)
				LCIW_SEL_IRQ_MASK: rdata_next[6:0] = mask_view;
				LCIW_SEL_IRQ_STATUS: rdata_next[6:0] = pend_view & mask_view;
				LCIW_SEL_IRQ_RAW: rdata_next[6:0] = pend_view;
				LCIW_SEL_LOCK_MODE: rdata_next[`LCIW_LOCK_EN_BIT] = lock_en_reg;
				LCIW_SEL_LOCK_STATUS: begin
					rdata_next[`LCIW_VIOL_FLAG_BIT] = viol_flag_reg;
					rdata_next[`LCIW_VIOL_SRC_MSB:`LCIW_VIOL_SRC_LSB] = viol_src_reg;
				end
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lock_en_reg <= `LCIW_LOCK_EN_RESET;
			viol_flag_reg <= 1'b0;
			viol_src_reg <= 16'h0000;
			cfg_wr_reg <= 1'b0;
			cfg_addr_reg <= 32'h0000_0000;
			cfg_wdata_reg <= 32'h0000_0000;
			rdata_reg <= 32'h0000_0000;
		end else begin
			lock_en_reg <= lock_en_next;
			viol_flag_reg <= viol_flag_next;
			viol_src_reg <= viol_src_next;
			cfg_wr_reg <= cfg_wr_next;
			cfg_addr_reg <= cfg_addr_next;
			cfg_wdata_reg <= cfg_wdata_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign lock_enable_o = lock_en_reg;
	assign cfg_wr_o = cfg_wr_reg;
	assign cfg_addr_o = cfg_addr_reg;
	assign cfg_wdata_o = cfg_wdata_reg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence s_key_write;
		lock_write && key_ok;
	endsequence

	sequence s_blocked_write;
		prot_write && lock_en_reg;
	endsequence

	property p_disable_clears;
		(disable_cmd != 7'h00 && enable_cmd == 7'h00) |=> ((mask_view & $past(disable_cmd)) == 7'h00);
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("mask bit survived disable");

	property p_enable_sets;
		(enable_cmd != 7'h00) |=> ((mask_view & $past(enable_cmd)) == $past(enable_cmd));
	endproperty
	a_enable_sets: assert property (p_enable_sets) else $error("mask bit not set by enable");

	property p_mask_read;
		(rd_i && sel == LCIW_SEL_IRQ_MASK) |=> (rdata_o == {25'h0, $past(mask_view)});
	endproperty
	a_mask_read: assert property (p_mask_read) else $error("mask view read wrong");

	property p_status_read;
		(rd_i && sel == LCIW_SEL_IRQ_STATUS)
			|=> (rdata_o == {25'h0, $past(pend_view) & $past(mask_view)});
	endproperty
	a_status_read: assert property (p_status_read) else $error("status view read wrong");

	property p_clear_works;
		(clear_cmd != 7'h00 && (irq_raw_i & clear_cmd) == 7'h00 && force_cmd == 7'h00)
			|=> ((pend_view & $past(clear_cmd)) == 7'h00);
	endproperty
	a_clear_works: assert property (p_clear_works) else $error("pending bit survived clear");

	property p_force_sets;
		(force_cmd != 7'h00) |=> ((pend_view & $past(force_cmd)) == $past(force_cmd)) ##1
			((pend_view & $past(force_cmd, 2)) == $past(force_cmd, 2)
			|| $past(clear_cmd) != 7'h00);
	endproperty
	a_force_sets: assert property (p_force_sets) else $error("forced bit not held");

	property p_raw_seen;
		(irq_raw_i != 7'h00) |=> ((pend_view & $past(irq_raw_i) & `LCIW_IRQ_VALID)
			== ($past(irq_raw_i) & `LCIW_IRQ_VALID));
	endproperty
	a_raw_seen: assert property (p_raw_seen) else $error("raw condition not latched");

	property p_reserved_bit;
		(mask_view[3] == 1'b0) && (pend_view[3] == 1'b0);
	endproperty
	a_reserved_bit: assert property (p_reserved_bit) else $error("reserved bit set");

	property p_key_write;
		s_key_write |=> (lock_enable_o == $past(wdata_i[`LCIW_LOCK_EN_BIT]));
	endproperty
	a_key_write: assert property (p_key_write) else $error("keyed lock write ignored");

	property p_bad_key;
		(lock_write && !key_ok) |=> $stable(lock_enable_o);
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("lock moved on wrong key");

	property p_key_reads_zero;
		(rd_i && sel == LCIW_SEL_LOCK_MODE) |=> (rdata_o[31:1] == 31'h0000_0000);
	endproperty
	a_key_reads_zero: assert property (p_key_reads_zero) else $error("key field read nonzero");

	property p_blocked;
		s_blocked_write |=> !cfg_wr_o ##1 (viol_flag_reg || $past(viol_read));
	endproperty
	a_blocked: assert property (p_blocked) else $error("protected write passed");

	property p_violation_logged;
		s_blocked_write |=> (viol_flag_reg && viol_src_reg == $past(addr_i[15:0]));
	endproperty
	a_violation_logged: assert property (p_violation_logged) else $error("violation lost");

	property p_violation_read_clears;
		(viol_read && !blocked_write) |=> (!viol_flag_reg && viol_src_reg == 16'h0000);
	endproperty
	a_violation_read_clears: assert property (p_violation_read_clears) else $error("status kept");

	property p_irq_line;
		irq_o == |(pend_view & mask_view);
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("interrupt line mismatch");

	property p_unlocked_pass;
		(prot_write && !lock_en_reg) |=> (cfg_wr_o && cfg_addr_o == $past(addr_i));
	endproperty
	a_unlocked_pass: assert property (p_unlocked_pass) else $error("open write not forwarded");

	// A zero command word must leave every mask bit alone.
	property p_mask_hold;
		(enable_cmd == 7'h00 && disable_cmd == 7'h00) |=> $stable(mask_view);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("mask moved");

	property p_pend_hold;
		(clear_cmd == 7'h00) |=> ((pend_view & $past(pend_view)) == $past(pend_view));
	endproperty
	a_pend_hold: assert property (p_pend_hold) else $error("pending bit lost");

	property p_lock_hold;
		(!lock_write) |=> $stable(lock_enable_o);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock moved");

	property p_raw_read;
		(rd_i && sel == LCIW_SEL_IRQ_RAW) |=> (rdata_o == {25'h0, $past(pend_view)});
	endproperty
	a_raw_read: assert property (p_raw_read) else $error("raw view read wrong");

	property p_violation_read;
		viol_read
			|=> (rdata_o == {8'h00, $past(viol_src_reg), 7'h00, $past(viol_flag_reg)});
	endproperty
	a_violation_read: assert property (p_violation_read) else $error("lock status read");

	// Stale read data would be taken by a master that samples one cycle late.
	property p_read_idle;
		(!rd_i) |=> (rdata_o == 32'h0000_0000);
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data left standing");
endmodule : lciw_top

`default_nettype wire

// >>> testbench/lcd_irq_and_write_protect_test.sv
// Self-checking bench of the display interrupt and write lock block.
`timescale 1ns/1ps
`default_nettype none
`include "lciw_cfg.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module lcd_irq_and_write_protect_test;
	import lciw_pkg::*;
	localparam lciw_word_t a_en = `LCIW_OFS_IRQ_ENABLE;
	localparam lciw_word_t a_dis = `LCIW_OFS_IRQ_DISABLE;
	localparam lciw_word_t a_msk = `LCIW_OFS_IRQ_MASK;
	localparam lciw_word_t a_st = `LCIW_OFS_IRQ_STATUS;
	localparam lciw_word_t a_clr = `LCIW_OFS_IRQ_CLEAR;
	localparam lciw_word_t a_frc = `LCIW_OFS_IRQ_FORCE;
	localparam lciw_word_t a_raw = `LCIW_OFS_IRQ_RAW;
	localparam lciw_word_t a_mode = `LCIW_OFS_LOCK_MODE;
	localparam lciw_word_t a_viol = `LCIW_OFS_LOCK_STATUS;
	localparam lciw_word_t keyed = {`LCIW_LOCK_KEY, 8'h00};
	logic clk_i;
	logic rst_b_i;
	lciw_word_t addr_i;
	lciw_word_t wdata_i;
	logic wr_i;
	logic rd_i;
	lciw_word_t rdata_o;
	lciw_irq_t irq_raw_i;
	logic irq_o;
	logic lock_enable_o;
	logic cfg_wr_o;
	lciw_word_t cfg_addr_o;
	lciw_word_t cfg_wdata_o;
	lciw_word_t d;
	int fails;
	int checks;

	lciw_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_raw_i(irq_raw_i), .irq_o(irq_o),
		.lock_enable_o(lock_enable_o), .cfg_wr_o(cfg_wr_o), .cfg_addr_o(cfg_addr_o),
		.cfg_wdata_o(cfg_wdata_o));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic wr(input lciw_word_t a, input lciw_word_t v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just past that edge.
	task automatic rchk(input string nm, input lciw_word_t a, input lciw_word_t e);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
		`CHK(nm, e, d)
	endtask : rchk

	task automatic t_reset;
		rchk("mask", a_msk, 32'h0000_0000);
		rchk("raw", a_raw, 32'h0000_0000);
		rchk("mode", a_mode, 32'h0000_0000);
		`CHK("irq_o", 1'b0, irq_o)
		`CHK("lock_enable_o", 1'b0, lock_enable_o)
		$display("done reset");
	endtask : t_reset

	task automatic t_mask;
		lciw_word_t m;
		m = 32'h0000_0000;
		for (int b = 0; b < 7; b++) begin
			wr(a_en, 32'h0000_0001 << b);
			if (b != 3) m[b] = 1'b1;
			rchk("mask set", a_msk, m);
		end
		wr(a_en, 32'h0000_0000);
		wr(a_dis, 32'h0000_0000);
		wr(a_msk, 32'h0000_0000);
		rchk("mask kept", a_msk, 32'h0000_0077);
		for (int b = 0; b < 7; b++) begin
			wr(a_dis, 32'h0000_0001 << b);
			if (b != 3) m[b] = 1'b0;
			rchk("mask cleared", a_msk, m);
		end
		rchk("write only", a_clr, 32'h0000_0000);
		rchk("unmapped", 32'h0050_0900, 32'h0000_0000);
		$display("done mask");
	endtask : t_mask

	task automatic t_force;
		lciw_word_t v;
		wr(a_en, 32'h0000_0077);
		for (int b = 0; b < 7; b++) begin
			v = (b == 3) ? 32'h0000_0000 : (32'h0000_0001 << b);
			wr(a_frc, 32'h0000_0001 << b);
			rchk("forced status", a_st, v);
			rchk("forced raw", a_raw, v);
			`CHK("irq_o forced", (b != 3), irq_o)
			wr(a_clr, ~v);
			rchk("other cleared", a_st, v);
			wr(a_clr, v);
			rchk("cleared", a_st, 32'h0000_0000);
			`CHK("irq_o cleared", 1'b0, irq_o)
		end
		wr(a_frc, 32'h0000_0000);
		rchk("force zero", a_raw, 32'h0000_0000);
		$display("done force");
	endtask : t_force

	task automatic t_raw;
		wr(a_dis, 32'h0000_0077);
		@(posedge clk_i);
		irq_raw_i <= 7'h04;
		rchk("raw view", a_raw, 32'h0000_0004);
		rchk("masked", a_st, 32'h0000_0000);
		`CHK("irq_o masked", 1'b0, irq_o)
		wr(a_en, 32'h0000_0004);
		rchk("unmasked", a_st, 32'h0000_0004);
		`CHK("irq_o live", 1'b1, irq_o)
		wr(a_clr, 32'h0000_0004);
		rchk("held", a_st, 32'h0000_0004);
		@(posedge clk_i);
		irq_raw_i <= 7'h08;
		wr(a_clr, 32'h0000_0004);
		rchk("gone", a_raw, 32'h0000_0000);
		`CHK("irq_o idle", 1'b0, irq_o)
		@(posedge clk_i);
		irq_raw_i <= 7'h00;
		$display("done raw");
	endtask : t_raw

	task automatic t_lock;
		wr(32'h0050_0804, 32'h0000_00A5);
		#1;
		`CHK("cfg_wr_o", 1'b1, cfg_wr_o)
		`CHK("cfg_addr_o", 32'h0050_0804, cfg_addr_o)
		`CHK("cfg_wdata_o", 32'h0000_00A5, cfg_wdata_o)
		@(posedge clk_i);
		#1;
		`CHK("cfg_wr_o end", 1'b0, cfg_wr_o)
		wr(a_mode, 32'h1234_5601);
		rchk("bad key", a_mode, 32'h0000_0000);
		wr(a_mode, keyed | 32'h0000_0001);
		rchk("locked", a_mode, 32'h0000_0001);
		`CHK("lock_enable_o on", 1'b1, lock_enable_o)
		wr(32'h0050_0838, 32'h0000_005A);
		#1;
		`CHK("blocked", 1'b0, cfg_wr_o)
		rchk("violation", a_viol, 32'h0008_3801);
		rchk("violation read", a_viol, 32'h0000_0000);
		wr(a_mode, 32'h0000_0000);
		rchk("still locked", a_mode, 32'h0000_0001);
		wr(a_mode, keyed);
		rchk("unlocked", a_mode, 32'h0000_0000);
		`CHK("lock_enable_o off", 1'b0, lock_enable_o)
		wr(32'h0050_0838, 32'h0000_005A);
		#1;
		`CHK("passed", 1'b1, cfg_wr_o)
		$display("done lock");
	endtask : t_lock

	// A reset in mid-run must drop masks, pending conditions and the lock together.
	task automatic t_rerun;
		wr(a_en, 32'h0000_0077);
		wr(a_frc, 32'h0000_0041);
		wr(a_mode, keyed | 32'h0000_0001);
		#1;
		`CHK("irq_o before reset", 1'b1, irq_o)
		`CHK("lock_enable_o before reset", 1'b1, lock_enable_o)
		@(posedge clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		#1;
		`CHK("irq_o after reset", 1'b0, irq_o)
		`CHK("lock_enable_o after reset", 1'b0, lock_enable_o)
		rchk("mask after reset", a_msk, 32'h0000_0000);
		rchk("raw after reset", a_raw, 32'h0000_0000);
		$display("done rerun");
	endtask : t_rerun

	task automatic end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		fails = 0;
		checks = 0;
		rst_b_i = 1'b0;
		addr_i = 32'h0000_0000;
		wdata_i = 32'h0000_0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		irq_raw_i = 7'h00;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		t_reset();
		t_mask();
		t_force();
		t_raw();
		t_lock();
		t_rerun();
		end_of_test();
	end

	// The tests need well under a thousand cycles; this span leaves ample margin.
	initial begin
		#50000;
		fails++;
		end_of_test();
	end
endmodule : lcd_irq_and_write_protect_test
`default_nettype wire
